// ===== src/itp_pkg.sv
/*
 Shared types and constants of the two-wire master transmit path.
 Assumes a single 50 MHz clock and a synchronous active-high reset.
*/
package itp_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ   = 50_000_000;
   localparam int unsigned SCL_HZ   = 100_000;
   // Four quarter phases per bit on the line
   localparam int unsigned QTR_CYC  = CLK_HZ / (4 * SCL_HZ);

   // -----------------------------------------------------------------
   // Field positions and widths
   // -----------------------------------------------------------------
   localparam int unsigned WORD_W   = 24;
   localparam int unsigned ADDR_MSB = 23;
   localparam int unsigned ADDR_LSB = 16;
   localparam int unsigned RW_BIT   = 16;
   localparam logic [2:0]  BIT_LAST = 3'h7;
   localparam logic [1:0]  BYTE_MAX = 2'h2;
   localparam logic [1:0]  PH_LOW   = 2'h0;
   localparam logic [1:0]  PH_RISE  = 2'h1;
   localparam logic [1:0]  PH_HIGH  = 2'h2;
   localparam logic [1:0]  PH_FALL  = 2'h3;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_START = 6'h02,
      ST_BIT   = 6'h04,
      ST_ACK   = 6'h08,
      ST_STALL = 6'h10,
      ST_STOP  = 6'h20
   } itp_fsm_t;

   typedef struct packed {
      logic       port_enable_bit;
      logic       two_wire_select_bit;
      logic       master_select_bit;
      logic [1:0] word_length_select;
      logic       idle_request_bit;
   } itp_ctrl_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe_n;
      logic sda_o;
      logic sda_oe_n;
   } itp_pin_out_t;

   typedef struct packed {
      itp_fsm_t    state;
      logic [1:0]  phase;
      logic [23:0] bit_shift_register;
      logic [23:0] transmit_holding_register;
      logic        hold_full;
      logic [2:0]  bit_cnt;
      logic [1:0]  byte_cnt;
      logic        addr_phase;
      logic        rw;
      logic        tx_session;
      logic        ack_high;
      logic        transmit_empty_flag;
      logic        bus_error_flag;
      logic        scl_low;
      logic        sda_low;
   } itp_state_t;

   localparam itp_state_t STATE_RST = '{
      state: ST_IDLE, phase: 2'h0, bit_shift_register: 24'h00_0000,
      transmit_holding_register: 24'h00_0000, hold_full: 1'b0,
      bit_cnt: 3'h0, byte_cnt: 2'h0, addr_phase: 1'b0, rw: 1'b0,
      tx_session: 1'b0, ack_high: 1'b0, transmit_empty_flag: 1'b1,
      bus_error_flag: 1'b0, scl_low: 1'b0, sda_low: 1'b0};

endpackage

// ===== src/itp_sync.sv
/*
 Two-flop synchroniser for line levels.
 Assumes inputs are asynchronous levels; only the second flop is read.
*/
`timescale 1ns/10ps
module itp_sync #(
   parameter int unsigned W = 2
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= '1;
         q    <= '1;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // itp_sync

// ===== src/itp_qtr_div.sv
/*
 Divider giving a one-cycle pulse per quarter bit of the line clock.
 Assumes the system clock; cleared with the port's individual reset.
*/
`timescale 1ns/10ps
module itp_qtr_div #(
   parameter int unsigned DIV = itp_pkg::QTR_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Quarter-bit enable
   output logic      tick
);
   logic [15:0] cnt;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt  <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt == 16'(DIV - 1)) begin
         cnt  <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule // itp_qtr_div

// ===== src/itp_master_tx.sv
/*
 Two-wire bus master: address phase and transmit session of the serial
 host port, plus its behaviour during the processor stop state.
 Assumes control bits arrive as plain ports on clk, the line pins are
 open drain with external pull-ups, and the holding register is fed
 by a valid/ready write port from software or DMA.
*/
// Functional notes
// (R01) Address byte acked with direction bit clear starts a transmit session.
// (R02) Session start loads shifter from holding register; bits go out MSB first.
// (R03) Ninth pulse samples data line; low acknowledge continues with next byte.
// (R04) No acknowledge sets bus error flag, sends stop, ends session.
// (R05) Next word is loaded only after whole word, length per word select.
// (R06) Software sizes frames in whole words; address byte not counted.
// (R07) In transmit session the receive FIFO transfers are blocked.
// (R08) Each hand-over to shifter sets transmit empty flag, accepts new word.
// (R09) Shifter and holding register empty: clock held low until new data.
// (R10) Idle request while stalled releases clock, sends stop, ends session.
// (R11) Processor stop state holds the port in individual reset, no transfers.
// (R12) Stop-state reset in two-wire mode releases all pins.
// (R13) Stop-state reset in other mode leaves pin states unchanged.
// (R14) Stop-state reset returns status and paths to hardware reset values.
// (R15) Control bits keep their values through stop-state reset.
// (R16) Software should disable the port before entering stop state.
// (R17) Software sets enable, two-wire and master bits; clock rate first.
// (R18) Write while idle sends start then only the top address byte.
// (R19) Stop: data line released low to high while clock line is high.
`timescale 1ns/10ps
module itp_master_tx #(
   parameter int unsigned QTR_CYC = itp_pkg::QTR_CYC
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Processor stop state
   input  wire logic                 stop_state,
   // Control bits, held outside
   input  wire itp_pkg::itp_ctrl_t   ctrl,
   // Holding register write
   input  wire logic                 wr_valid,
   input  wire logic [23:0]          wr_data,
   output logic                      wr_ready,
   // Status
   output logic                      transmit_empty_flag,
   output logic                      bus_error_flag,
   input  wire logic                 bus_error_clear,
   output logic                      idle_flag,
   output logic                      tx_session,
   output logic                      rx_transfer_enable,
   // Line pins
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output itp_pkg::itp_pin_out_t     pins
);

   // ---------------------------------------------------------------
   // Line sampling and bit timing
   // ---------------------------------------------------------------
   itp_pkg::itp_state_t s;
   itp_pkg::itp_state_t next_s;
   logic [1:0]          line_s;
   logic                scl_s;
   logic                sda_s;
   logic                tick;
   logic                step;
   logic                wr_fire;
   logic                master_on;
   logic [1:0]          last_byte;

   itp_sync #(
      .W (2)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({scl_i, sda_i}),
      .q   (line_s)
   );

   assign scl_s = line_s[1];
   assign sda_s = line_s[0];

   // (R11) Divider held in reset during stop
   itp_qtr_div #(
      .DIV (QTR_CYC)
   ) u_div (
      .clk  (clk),
      .rst  (rst | stop_state),
      .tick (tick)
   );

   // Slave may stretch the clock: high phase waits for the line
   assign step = tick & ~((s.phase == itp_pkg::PH_HIGH) & ~scl_s);

   assign master_on = ctrl.port_enable_bit & ctrl.two_wire_select_bit
                    & ctrl.master_select_bit;

   // (R05) Bytes per word from the word select, capped at three
   assign last_byte = (ctrl.word_length_select > itp_pkg::BYTE_MAX) ?
                      itp_pkg::BYTE_MAX : ctrl.word_length_select;

   // (R08) Holding register open whenever empty, master on and not in stop state
   assign wr_ready = ~stop_state & master_on &
                     ((s.state == itp_pkg::ST_IDLE) | ~s.hold_full);
   assign wr_fire  = wr_valid & wr_ready;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;

      // Set wins: the set paths below come after the clear
      if (bus_error_clear) begin
         next_s.bus_error_flag = 1'b0;
      end

      if (wr_fire && s.state != itp_pkg::ST_IDLE) begin
         next_s.transmit_holding_register = wr_data;
         next_s.hold_full                 = 1'b1;
         next_s.transmit_empty_flag       = 1'b0;
      end

      if (step && s.state != itp_pkg::ST_IDLE && s.state != itp_pkg::ST_STALL) begin
         next_s.phase = s.phase + 2'h1;
      end

      case (s.state)
         itp_pkg::ST_IDLE: begin
            next_s.scl_low    = 1'b0;
            next_s.sda_low    = 1'b0;
            next_s.tx_session = 1'b0;
            // (R18) Write while idle is the address byte only
            if (wr_fire) begin
               next_s.bit_shift_register =
                  {wr_data[itp_pkg::ADDR_MSB:itp_pkg::ADDR_LSB], 16'h0000};
               next_s.rw         = wr_data[itp_pkg::RW_BIT];
               next_s.addr_phase = 1'b1;
               next_s.bit_cnt    = itp_pkg::BIT_LAST;
               next_s.phase      = itp_pkg::PH_LOW;
               next_s.state      = itp_pkg::ST_START;
            end
         end

         itp_pkg::ST_START: begin
            if (step) begin
               case (s.phase)
                  // (R18) Data falls while clock is high
                  itp_pkg::PH_LOW: begin
                     next_s.sda_low = 1'b1;
                  end
                  itp_pkg::PH_FALL: begin
                     next_s.scl_low = 1'b1;
                     next_s.state   = itp_pkg::ST_BIT;
                  end
                  default: begin
                  end
               endcase
            end
         end

         itp_pkg::ST_BIT: begin
            if (step) begin
               case (s.phase)
                  // (R02) MSB first
                  itp_pkg::PH_LOW: begin
                     next_s.sda_low = ~s.bit_shift_register[itp_pkg::WORD_W-1];
                  end
                  itp_pkg::PH_RISE: begin
                     next_s.scl_low = 1'b0;
                  end
                  itp_pkg::PH_FALL: begin
                     next_s.scl_low            = 1'b1;
                     next_s.bit_shift_register = {s.bit_shift_register[22:0], 1'b0};
                     if (s.bit_cnt == 3'h0) begin
                        next_s.state = itp_pkg::ST_ACK;
                     end else begin
                        next_s.bit_cnt = s.bit_cnt - 3'h1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end

         itp_pkg::ST_ACK: begin
            if (step) begin
               case (s.phase)
                  itp_pkg::PH_LOW: begin
                     next_s.sda_low = 1'b0;
                  end
                  itp_pkg::PH_RISE: begin
                     next_s.scl_low = 1'b0;
                  end
                  // (R03) Ninth pulse sample
                  itp_pkg::PH_HIGH: begin
                     next_s.ack_high = sda_s;
                  end
                  default: begin
                     next_s.scl_low = 1'b1;
                     if (s.ack_high) begin
                        // (R04) No acknowledge ends the session
                        next_s.bus_error_flag = 1'b1;
                        next_s.state          = itp_pkg::ST_STOP;
                     end else if (s.addr_phase) begin
                        next_s.addr_phase = 1'b0;
                        if (s.rw) begin
                           // Receive session lives outside this path
                           next_s.state = itp_pkg::ST_STOP;
                        end else begin
                           // (R01) Direction clear opens transmit
                           next_s.tx_session = 1'b1;
                           next_s.state      = itp_pkg::ST_STALL;
                        end
                     end else if (s.byte_cnt == last_byte) begin
                        // (R05) Word done, fetch at stall check
                        next_s.state = itp_pkg::ST_STALL;
                     end else begin
                        // (R03) Acked, next byte of word
                        next_s.byte_cnt = s.byte_cnt + 2'h1;
                        next_s.bit_cnt  = itp_pkg::BIT_LAST;
                        next_s.state    = itp_pkg::ST_BIT;
                     end
                  end
               endcase
            end
         end

         itp_pkg::ST_STALL: begin
            // (R09) Clock held low while nothing waits
            next_s.scl_low = 1'b1;
            if (s.hold_full) begin
               // (R02) Load shifter from holding register
               next_s.bit_shift_register  = s.transmit_holding_register;
               next_s.hold_full           = 1'b0;
               // (R08) Hand-over sets the empty flag
               next_s.transmit_empty_flag = 1'b1;
               next_s.bit_cnt             = itp_pkg::BIT_LAST;
               next_s.byte_cnt            = 2'h0;
               next_s.phase               = itp_pkg::PH_LOW;
               next_s.state               = itp_pkg::ST_BIT;
            end else if (ctrl.idle_request_bit) begin
               // (R10) Idle request restarts clock for stop
               next_s.phase = itp_pkg::PH_LOW;
               next_s.state = itp_pkg::ST_STOP;
            end
         end

         itp_pkg::ST_STOP: begin
            if (step) begin
               case (s.phase)
                  itp_pkg::PH_LOW: begin
                     next_s.sda_low = 1'b1;
                  end
                  itp_pkg::PH_RISE: begin
                     next_s.scl_low = 1'b0;
                  end
                  // (R19) Data rises while clock is high
                  itp_pkg::PH_FALL: begin
                     next_s.sda_low    = 1'b0;
                     next_s.tx_session = 1'b0;
                     next_s.state      = itp_pkg::ST_IDLE;
                  end
                  default: begin
                  end
               endcase
            end
         end

         default: begin
            next_s = itp_pkg::STATE_RST;
         end
      endcase

      // (R11) Stop state: individual reset, no transfers
      if (stop_state) begin
         // (R14) Status and both paths back to reset values
         next_s = itp_pkg::STATE_RST;
         // (R13) Other modes keep their pin levels
         if (!ctrl.two_wire_select_bit) begin
            next_s.scl_low = s.scl_low;
            next_s.sda_low = s.sda_low;
         end
         // (R12) Two-wire mode takes the reset value: pins released
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // (R15) Control bits are ports and are never touched here
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= itp_pkg::STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Open drain: output level is always low, the enable does the work
   assign pins.scl_o    = 1'b0;
   assign pins.sda_o    = 1'b0;
   assign pins.scl_oe_n = ~s.scl_low;
   assign pins.sda_oe_n = ~s.sda_low;

   assign transmit_empty_flag = s.transmit_empty_flag;
   assign bus_error_flag      = s.bus_error_flag;
   assign idle_flag           = (s.state == itp_pkg::ST_IDLE);
   assign tx_session          = s.tx_session;
   // (R07) Receive transfers blocked in transmit session
   assign rx_transfer_enable  = ~s.tx_session & ~s.addr_phase
                              & (s.state != itp_pkg::ST_IDLE) & s.rw;

endmodule // itp_master_tx

// ===== verif/itp_slave_model.sv
/*
 Behavioural two-wire slave receiver on the far side of the port.
 Assumes pulled-up open-drain lines; acks every byte but the one named.
*/
`timescale 1ns/10ps
module itp_slave_model (
   // Line levels
   input  wire logic       scl,
   input  wire logic       sda,
   // Byte index to refuse, FF for none
   input  wire logic [7:0] nack_at,
   // High pulls the data line low
   output logic            sda_pull
);
   // -----------------------------------------------------------------
   // Receive state
   // -----------------------------------------------------------------
   logic [7:0] rx [0:63];
   logic [7:0] sh;
   int         n_bytes  = 0;
   int         n_stops  = 0;
   int         bit_n    = 0;
   logic       in_frame = 1'h0;

   initial sda_pull = 1'h0;

   always @(negedge sda) begin
      if (scl) begin
         in_frame = 1'h1;
         bit_n    = 0;
         sda_pull = 1'h0;
      end
   end

   always @(posedge sda) begin
      if (scl && in_frame) begin
         in_frame = 1'h0;
         n_stops++;
      end
   end

   always @(posedge scl) begin
      if (in_frame && bit_n < 8) begin
         sh = {sh[6:0], sda};
         bit_n++;
      end
   end

   always @(negedge scl) begin
      if (in_frame && bit_n == 8) begin
         sda_pull            = (n_bytes[7:0] != nack_at);
         rx[n_bytes % 64]    = sh;
         bit_n               = 9;
      end else if (in_frame && bit_n == 9) begin
         // Released so the master owns the line again
         sda_pull = 1'h0;
         n_bytes++;
         bit_n    = 0;
      end
   end
endmodule // itp_slave_model

// ===== verif/itp_master_tx_chk.sv
/*
 Concurrent checks on the ports of the two-wire master transmit path.
 Assumes one clock domain; bound onto every instance of the top module.
*/
`timescale 1ns/10ps
module itp_master_tx_chk #(
   parameter int unsigned QTR_CYC = 2
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // Stop state and control
   input wire logic                  stop_state,
   input wire itp_pkg::itp_ctrl_t    ctrl,
   // Write port
   input wire logic                  wr_valid,
   input wire logic                  wr_ready,
   // Status
   input wire logic                  transmit_empty_flag,
   input wire logic                  bus_error_flag,
   input wire logic                  idle_flag,
   input wire logic                  tx_session,
   input wire logic                  rx_transfer_enable,
   // Pins
   input wire itp_pkg::itp_pin_out_t pins
);
   // Bounds scale with the QTR_CYC quarter bit that the bind passes in
   localparam int START_MAX = 8 * QTR_CYC + 4;
   localparam int STOP_MAX  = 16 * QTR_CYC + 8;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_start;
      ##[2:START_MAX] (!pins.sda_oe_n && pins.scl_oe_n);
   endsequence
   sequence s_stop_done;
      ##[0:STOP_MAX] (idle_flag && pins.scl_oe_n && pins.sda_oe_n);
   endsequence

   property p_rx_blocked;
      tx_session |-> !rx_transfer_enable;
   endproperty
   property p_ss_release;
      stop_state && ctrl.two_wire_select_bit |=> pins.scl_oe_n && pins.sda_oe_n;
   endproperty
   property p_ss_keep;
      stop_state && !ctrl.two_wire_select_bit |=> $stable(pins);
   endproperty
   property p_ss_status;
      stop_state |=> idle_flag && transmit_empty_flag && !bus_error_flag && !tx_session;
   endproperty
   property p_ss_no_wr;
      stop_state |-> !wr_ready;
   endproperty
   property p_load_clears;
      wr_valid && wr_ready && !idle_flag |=> ##[0:1] !transmit_empty_flag;
   endproperty
   property p_addr_idle;
      wr_valid && wr_ready && idle_flag |=> !idle_flag;
   endproperty
   property p_addr_start;
      wr_valid && wr_ready && idle_flag |-> s_start;
   endproperty
   property p_nack_stop;
      $rose(bus_error_flag) |-> s_stop_done;
   endproperty
   property p_stop_edge;
      $rose(pins.sda_oe_n) && pins.scl_oe_n && !stop_state && !$past(stop_state)
         |-> s_stop_done;
   endproperty

   a_rx_blocked: assert property (p_rx_blocked)
      else $error("receive transfer open in transmit session");
   a_ss_release: assert property (p_ss_release)
      else $error("pins not released in stop state");
   a_ss_keep: assert property (p_ss_keep)
      else $error("pins changed in stop state, other mode");
   a_ss_status: assert property (p_ss_status)
      else $error("status not reset in stop state");
   a_ss_no_wr: assert property (p_ss_no_wr)
      else $error("write accepted in stop state");
   a_load_clears: assert property (p_load_clears)
      else $error("empty flag kept after data write");
   a_addr_idle: assert property (p_addr_idle)
      else $error("idle kept after address write");
   a_addr_start: assert property (p_addr_start)
      else $error("no start after address write");
   a_nack_stop: assert property (p_nack_stop)
      else $error("no stop after bus error");
   a_stop_edge: assert property (p_stop_edge)
      else $error("data release with clock high not ending in idle");
endmodule // itp_master_tx_chk

bind itp_master_tx itp_master_tx_chk #(.QTR_CYC(QTR_CYC)) u_itp_master_tx_chk (
   .clk(clk), .rst(rst), .stop_state(stop_state), .ctrl(ctrl), .wr_valid(wr_valid),
   .wr_ready(wr_ready), .transmit_empty_flag(transmit_empty_flag),
   .bus_error_flag(bus_error_flag), .idle_flag(idle_flag), .tx_session(tx_session),
   .rx_transfer_enable(rx_transfer_enable), .pins(pins));

// ===== verif/itp_master_tx_bench.sv
/*
 Self-checking bench of the two-wire master transmit path.
 Assumes the slave model on pulled-up lines and a two-cycle quarter bit.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module itp_master_tx_bench;
   localparam int unsigned QTR = 2;
   logic                  clk = 1'h0;
   logic                  rst = 1'h1;
   logic                  stop_state = 1'h0;
   itp_pkg::itp_ctrl_t    ctrl = '{1'h1, 1'h1, 1'h1, 2'h0, 1'h0};
   logic                  wr_valid = 1'h0;
   logic [23:0]           wr_data = 24'h00_0000;
   logic                  bus_error_clear = 1'h0;
   logic [7:0]            nack_at = 8'hFF;
   logic                  wr_ready, tef, bef, idle_flag, tx_session, rx_en;
   itp_pkg::itp_pin_out_t pins;
   wire logic             scl_w, sda_w, sda_pull;
   int                    n_mismatch = 0;
   int                    cmp_count = 0;
   int                    n0, s0, nb;

   // Pull-ups win wherever nobody pulls low
   assign scl_w = pins.scl_oe_n ? 1'h1 : pins.scl_o;
   assign sda_w = (pins.sda_oe_n ? 1'h1 : pins.sda_o) & !sda_pull;

   itp_master_tx #(.QTR_CYC(QTR)) u_itp_master_tx (.clk(clk), .rst(rst),
      .stop_state(stop_state), .ctrl(ctrl), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .transmit_empty_flag(tef), .bus_error_flag(bef),
      .bus_error_clear(bus_error_clear), .idle_flag(idle_flag), .tx_session(tx_session),
      .rx_transfer_enable(rx_en), .scl_i(scl_w), .sda_i(sda_w), .pins(pins));
   itp_slave_model u_itp_slave_model (.scl(scl_w), .sda(sda_w), .nack_at(nack_at),
      .sda_pull(sda_pull));

   always #10 clk = ~clk;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [23:0] d);
      int k;
      tick(1);
      for (k = 0; k < 300 && wr_ready !== 1'h1; k++) tick(1);
      `CHK("wr_ready", 1'h1, wr_ready)
      wr_valid = 1'h1;
      wr_data  = d;
      tick(1);
      wr_valid = 1'h0;
   endtask
   task wait_bytes(input int n);
      int k;
      for (k = 0; k < 3000 && u_itp_slave_model.n_bytes < n; k++) tick(1);
      `CHK("n_bytes", n, u_itp_slave_model.n_bytes)
   endtask
   task wait_idle;
      int k;
      for (k = 0; k < 500 && idle_flag !== 1'h1; k++) tick(1);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task t_reset;
      `CHK("idle_flag", 1'h1, idle_flag)
      `CHK("tef", 1'h1, tef)
      `CHK("bef", 1'h0, bef)
      `CHK("pins", 2'h3, {pins.scl_oe_n, pins.sda_oe_n})
      $display("test t_reset done");
   endtask
   task t_word_len;
      int k, j;
      logic [23:0] w;
      w = 24'h96_5A3C;
      for (k = 0; k < 4; k++) begin
         ctrl.word_length_select = k[1:0];
         nb = (k == 0) ? 1 : (k == 1) ? 2 : 3;
         n0 = u_itp_slave_model.n_bytes;
         s0 = u_itp_slave_model.n_stops;
         wr(24'hA4_0000);
         wr(w);
         tick(1);
         `CHK("tef_wr", 1'h0, tef)
         wait_bytes(n0 + 1 + nb);
         `CHK("tx_session", 1'h1, tx_session)
         `CHK("rx_en", 1'h0, rx_en)
         `CHK("addr", 8'hA4, u_itp_slave_model.rx[n0 % 64])
         for (j = 0; j < nb; j++)
            `CHK("data", w[23-8*j -: 8], u_itp_slave_model.rx[(n0+1+j) % 64])
         tick(100);
         `CHK("stall_scl", 1'h0, pins.scl_oe_n)
         `CHK("stall_cnt", n0 + 1 + nb, u_itp_slave_model.n_bytes)
         `CHK("tef_load", 1'h1, tef)
         wr(24'hC3_A55A);
         wait_bytes(n0 + 1 + 2 * nb);
         `CHK("resume", 8'hC3, u_itp_slave_model.rx[(n0+1+nb) % 64])
         ctrl.idle_request_bit = 1'h1;
         wait_idle;
         ctrl.idle_request_bit = 1'h0;
         `CHK("stops", s0 + 1, u_itp_slave_model.n_stops)
         `CHK("released", 2'h3, {pins.scl_oe_n, pins.sda_oe_n})
      end
      $display("test t_word_len done");
   endtask
   task t_nack;
      n0 = u_itp_slave_model.n_bytes;
      s0 = u_itp_slave_model.n_stops;
      ctrl.word_length_select = 2'h0;
      nack_at = 8'(n0 + 1);
      wr(24'h5C_0000);
      wr(24'h3C_0000);
      wait_bytes(n0 + 2);
      wait_idle;
      `CHK("bef", 1'h1, bef)
      `CHK("tx_nack", 1'h0, tx_session)
      `CHK("nack_stop", s0 + 1, u_itp_slave_model.n_stops)
      nack_at = 8'hFF;
      bus_error_clear = 1'h1;
      tick(1);
      bus_error_clear = 1'h0;
      tick(1);
      `CHK("bef_clr", 1'h0, bef)
      $display("test t_nack done");
   endtask
   task t_stop_state;
      n0 = u_itp_slave_model.n_bytes;
      ctrl.word_length_select = 2'h2;
      wr(24'h68_0000);
      wr(24'hF0_F0F0);
      wait_bytes(n0 + 1);
      tick(20);
      // stop entered with port still on
      stop_state = 1'h1;
      tick(1);
      `CHK("ss_pins", 2'h3, {pins.scl_oe_n, pins.sda_oe_n})
      `CHK("ss_idle", 1'h1, idle_flag)
      `CHK("ss_tef", 1'h1, tef)
      `CHK("ss_tx", 1'h0, tx_session)
      `CHK("ss_ready", 1'h0, wr_ready)
      tick(100);
      `CHK("ss_quiet", n0 + 1, u_itp_slave_model.n_bytes)
      stop_state = 1'h0;
      tick(2);
      `CHK("ss_ctrl", 1'h1, wr_ready)
      // Stall holds the clock low, then stop in other mode
      wr(24'h68_0000);
      wait_bytes(n0 + 2);
      tick(20);
      ctrl.two_wire_select_bit = 1'h0;
      stop_state = 1'h1;
      tick(2);
      `CHK("ss_other", 2'h1, {pins.scl_oe_n, pins.sda_oe_n})
      stop_state = 1'h0;
      ctrl.two_wire_select_bit = 1'h1;
      tick(2);
      $display("test t_stop_state done");
   endtask

   initial begin
      tick(20);
      rst = 1'h0;
      tick(1);
      t_reset;
      t_word_len;
      t_nack;
      t_stop_state;
      final_report;
   end

   // Some three thousand cycles expected; about thirteen times that is a hang
   initial begin
      #800_000;
      n_mismatch++;
      final_report;
   end
endmodule // itp_master_tx_bench
